// >>> logic/agp_cmd_consts.svh
`ifndef AGP_CMD_CONSTS_SVH
`define AGP_CMD_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_COMMAND        4'h0
`define OFS_STATUS         4'h4

// ****************************************************************
// Command register fields
// ****************************************************************
`define BIT_SBA_EN         9
`define BIT_OP_EN          8
`define BIT_ABOVE4G        5
`define BIT_FW_EN          4
`define RATE_LSB           0
`define RATE_W             3
`define RATE_1X            3'h1
`define RATE_2X            3'h2
`define RATE_4X            3'h4
`define CMD_RESET          32'h0000_0001
`define CMD_WMASK          32'h0000_0317

// ****************************************************************
// Status register fields
// ****************************************************************
`define ST_BUSY            0
`define ST_FAST            1
`define ST_RATE_BAD        2

`endif

// >>> logic/agp_cmd_pkg.sv
`default_nettype none
package agp_cmd_pkg;
    typedef enum logic [2:0] {
        REQ_IDLE = 3'b001,
        REQ_BUSY = 3'b010,
        REQ_SBA  = 3'b100
    } req_state_t;
    typedef enum logic [1:0] {
        WPROT_PCI  = 2'b01,
        WPROT_FAST = 2'b10
    } wprot_t;
endpackage : agp_cmd_pkg
`default_nettype wire

// >>> logic/agp_cmd_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "agp_cmd_consts.svh"
module agp_cmd_regs
    import agp_cmd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    input  wire logic        wrEn,
    input  wire logic [31:0] wrData,
    input  wire logic [3:0]  wrSel,
    output logic      [31:0] cmdQ
);
    logic [31:0] cmd_r;
    logic [31:0] cmd_nxt;
    logic [31:0] byteMask;
    logic [31:0] wrMask;
    genvar       g;

    // ****************************************************************
    // Command register with byte enables
    // ****************************************************************
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_byte
            assign byteMask[g*8 +: 8] = {8{wrSel[g]}};
        end
    endgenerate

    // Bits outside the writable mask keep their reset value
    always_comb
    begin
        wrMask  = byteMask & `CMD_WMASK;
        cmd_nxt = cmd_r;
        if (clkEn && wrEn)
        begin
            cmd_nxt = (cmd_r & ~wrMask) | (wrData & wrMask);
        end
        cmd_nxt[`BIT_ABOVE4G] = 1'b0; // Hardwired, see RULE3
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            cmd_r <= `CMD_RESET;
        else
            cmd_r <= cmd_nxt;
    end

    assign cmdQ = cmd_r;
endmodule : agp_cmd_regs
`default_nettype wire

// >>> logic/agp_target_command_control.sv
// Functional notes
// RULE1 - Accept PIPE when enabled; SBA also needs sideband
// RULE2 - Requests taken while enabled still complete
// RULE3 - Above-4GB enable reads zero, no high addresses
// RULE4 - Fast write off or 1X: PCI writes
// RULE5 - Fast write on, not 1X: fast writes
// RULE6 - Fast writes run at selected rate
// RULE7 - Disabled: ignore all requests including sync
// RULE8 - 1X sideband command in flight still issued
// RULE9 - Rate one-hot, 2X unsupported, both ends match
`timescale 1ns/1ps
`default_nettype none
`include "agp_cmd_consts.svh"
module agp_target_command_control
    import agp_cmd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        pipeReq,
    input  wire logic        sbaReq,
    input  wire logic        syncReq,
    input  wire logic        reqDone,
    input  wire logic        wrToMaster,
    output logic             reqAccept,
    output logic             reqActive,
    output logic             fastWrite,
    output logic             pciWrite,
    output logic [2:0]       rateOut
);
    logic [31:0] cmd;
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    req_state_t  st_r, st_nxt;
    logic        acc_r, acc_nxt;
    logic        act_r, act_nxt;
    logic        fw_r, fw_nxt, pw_r, pw_nxt;
    logic [2:0]  rate_r, rate_nxt;
    logic        opEn, sbaEn, fast_write_enable, rateOk, is1x, wrStb, fastSel;
    logic [2:0]  rate;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    // Write lands at the edge where the master samples ack high
    assign wrStb = clkEn && wb_cyc_i && wb_stb_i && wb_we_i && ack_r
                   && (wb_adr_i == `OFS_COMMAND);

    agp_cmd_regs u_regs (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .wrEn     (wrStb),
        .wrData   (wb_dat_i),
        .wrSel    (wb_sel_i),
        .cmdQ     (cmd)
    );

    assign opEn   = cmd[`BIT_OP_EN];
    assign sbaEn  = cmd[`BIT_SBA_EN];
    assign fast_write_enable   = cmd[`BIT_FW_EN];
    assign rate   = cmd[`RATE_LSB +: `RATE_W];
    // Only 1X and 4X are legal; anything else leaves writes on PCI
    assign rateOk = (rate == `RATE_1X) || (rate == `RATE_4X); // see RULE9
    assign is1x   = (rate == `RATE_1X);
    assign fastSel = fast_write_enable && rateOk && !is1x; // see RULE5

    always_comb
    begin
        ack_nxt = 1'b0;
        dat_nxt = dat_r;
        if (wb_cyc_i && wb_stb_i && !ack_r)
        begin
            ack_nxt = 1'b1;
            unique case (wb_adr_i)
                `OFS_COMMAND: dat_nxt = cmd; // Above-4GB bit always 0, see RULE3
                `OFS_STATUS:  dat_nxt = {29'h0, !rateOk, fw_r, st_r != REQ_IDLE};
                default:      dat_nxt = 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // Request acceptance
    // ****************************************************************
    always_comb
    begin
        st_nxt  = st_r;
        acc_nxt = 1'b0;
        unique case (st_r)
            REQ_IDLE:
            begin
                // Sync cycles and requests dropped while disabled, see RULE7
                if (opEn && (pipeReq || syncReq)) // see RULE1
                begin
                    acc_nxt = 1'b1;
                    st_nxt  = REQ_BUSY;
                end
                else if (opEn && sbaEn && sbaReq) // see RULE1
                begin
                    acc_nxt = 1'b1;
                    st_nxt  = is1x ? REQ_SBA : REQ_BUSY;
                end
            end
            // Enable is not looked at here: accepted work finishes, see RULE2
            REQ_BUSY:
                if (reqDone)
                    st_nxt = REQ_IDLE;
            // 1X sideband command keeps going after enable falls, see RULE8
            REQ_SBA:
                if (reqDone)
                    st_nxt = REQ_IDLE;
        endcase
        act_nxt = (st_nxt != REQ_IDLE);
    end

    // ****************************************************************
    // Write protocol selection
    // ****************************************************************
    always_comb
    begin
        fw_nxt   = fw_r;
        pw_nxt   = pw_r;
        rate_nxt = rate_r;
        if (wrToMaster)
        begin
            fw_nxt   = fastSel;                 // see RULE5
            pw_nxt   = !fastSel;                // see RULE4
            rate_nxt = fastSel ? rate : `RATE_1X; // see RULE6
        end
        else
        begin
            fw_nxt = 1'b0;
            pw_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_r  <= 1'b0;
            dat_r  <= 32'h0;
            st_r   <= REQ_IDLE;
            acc_r  <= 1'b0;
            act_r  <= 1'b0;
            fw_r   <= 1'b0;
            pw_r   <= 1'b0;
            rate_r <= `RATE_1X;
        end
        else if (clkEn)
        begin
            ack_r  <= ack_nxt;
            dat_r  <= dat_nxt;
            st_r   <= st_nxt;
            acc_r  <= acc_nxt;
            act_r  <= act_nxt;
            fw_r   <= fw_nxt;
            pw_r   <= pw_nxt;
            rate_r <= rate_nxt;
        end
    end

    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = dat_r;
    assign reqAccept = acc_r;
    assign reqActive = act_r;
    assign fastWrite = fw_r;
    assign pciWrite  = pw_r;
    assign rateOut   = rate_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_NO_ACC_DISABLED: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE7
        (clkEn && st_r == REQ_IDLE && !opEn) |=> !reqAccept)
        else $error("Request accepted while disabled");
    AST_SBA_NEEDS_EN: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE1
        (clkEn && st_r == REQ_IDLE && opEn && !pipeReq && !syncReq && sbaReq && !sbaEn)
        |=> !reqAccept)
        else $error("Sideband accepted without sideband enable");
    AST_PIPE_ACC: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE1
        (clkEn && st_r == REQ_IDLE && opEn && pipeReq) |=> (reqAccept && reqActive))
        else $error("Pipe request not accepted");
    AST_KEEP_BUSY: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE2
        (clkEn && st_r == REQ_BUSY && !reqDone) |=> reqActive)
        else $error("Accepted request dropped");
    AST_SBA_1X: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE8
        (clkEn && st_r == REQ_SBA && !reqDone && !opEn) |=> (st_r == REQ_SBA))
        else $error("1X sideband command abandoned");
    AST_ABOVE4G: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE3
        (wb_ack_o && $past(wb_adr_i) == `OFS_COMMAND) |-> !wb_dat_o[`BIT_ABOVE4G])
        else $error("Above-4GB bit read as one");
    AST_PCI_WR: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE4
        (clkEn && wrToMaster && (!fast_write_enable || is1x)) |=> (pciWrite && !fastWrite))
        else $error("Fast write used when disallowed");
    AST_FAST_WR: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE5
        (clkEn && wrToMaster && fast_write_enable && rate == `RATE_4X) |=> (fastWrite && !pciWrite))
        else $error("Fast write not used");
    AST_RATE: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE6
        fastWrite |-> (rateOut == `RATE_4X))
        else $error("Fast write at wrong rate");
    AST_RATE_LEGAL: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE9
        (clkEn && wrToMaster && rate == `RATE_2X) |=> !fastWrite)
        else $error("Unsupported rate used");
    CV_PIPE: cover property (@(posedge core_clk) disable iff (!resetn)
        reqAccept ##1 reqActive);
    CV_SBA1X: cover property (@(posedge core_clk) disable iff (!resetn)
        st_r == REQ_SBA && !opEn);
    AST_ACK_PULSE: assert property (@(posedge core_clk) disable iff (!resetn)
        (clkEn && wb_ack_o) |=> !wb_ack_o)
        else $error("Bus ack held longer than one cycle");
    CV_FAST: cover property (@(posedge core_clk) disable iff (!resetn) fastWrite);
    CV_PCI: cover property (@(posedge core_clk) disable iff (!resetn)
        pciWrite);
endmodule : agp_target_command_control
`default_nettype wire

// >>> verification/agp_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Graphics master stand-in
// ****************************************************************
module agp_master_model
(
    input  wire logic core_clk,
    output logic      pipeReq,
    output logic      sbaReq,
    output logic      syncReq,
    output logic      reqDone
);
    initial
    begin
        {pipeReq, sbaReq, syncReq, reqDone} = 4'h0;
    end

    // One line high for one cycle, then back to idle low; one request at a time
    task automatic pulse(input logic [3:0] which);
        @(posedge core_clk);
        {pipeReq, sbaReq, syncReq, reqDone} <= which;
        @(posedge core_clk);
        {pipeReq, sbaReq, syncReq, reqDone} <= 4'h0;
    endtask : pulse
endmodule : agp_master_model
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import agp_cmd_pkg::*;
    logic        core_clk = 1'b0;
    logic        resetn, cyc, stb, we, wrToMaster, clkEn;
    logic        reqAccept, reqActive, fastWrite, pciWrite, ack;
    logic        pipeReq, sbaReq, syncReq, reqDone;
    logic [3:0]  adr;
    logic [2:0]  rateOut;
    logic [31:0] dat, datO, rdat;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cycles = 0;

    always #20 core_clk = ~core_clk;

    agp_master_model M (.core_clk(core_clk), .pipeReq(pipeReq), .sbaReq(sbaReq),
        .syncReq(syncReq), .reqDone(reqDone));

    agp_target_command_control DUT (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .pipeReq(pipeReq),
        .sbaReq(sbaReq), .syncReq(syncReq), .reqDone(reqDone), .wrToMaster(wrToMaster),
        .reqAccept(reqAccept), .reqActive(reqActive), .fastWrite(fastWrite),
        .pciWrite(pciWrite), .rateOut(rateOut));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Classic cycle; no latency assumed, the timeout bounds the wait
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
        do @(posedge core_clk); while (ack !== 1'b1);
        rdat = datO;
        {cyc, stb, we} <= 3'h0;
    endtask : wb

    task automatic req(input logic [3:0] k, input logic e);
        M.pulse(k);
        #1 chk({30'h0, reqAccept, reqActive}, {30'h0, e, e});
    endtask : req

    task automatic wm(input logic [31:0] c, input logic f, input logic [2:0] r);
        wb(1'b1, 4'h0, c);
        @(posedge core_clk);
        wrToMaster <= 1'b1;
        @(posedge core_clk);
        #1 chk({27'h0, fastWrite, pciWrite, rateOut}, {27'h0, f, !f, r});
        @(posedge core_clk);
        wrToMaster <= 1'b0;
    endtask : wm

    // ****************************************************************
    // Tests
    // ****************************************************************
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        {resetn, cyc, stb, we, wrToMaster, adr, dat} = '0;
        clkEn = 1'b1;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        wb(1'b0, 4'h0, 32'h0);
        chk(rdat, 32'h0000_0001);
        wb(1'b1, 4'h0, 32'hffff_ffff);
        wb(1'b0, 4'h0, 32'h0);
        chk(rdat, 32'h0000_0317);
        wb(1'b0, 4'h8, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b1, 4'h0, 32'h0000_0201);
        req(4'h8, 1'b0);
        req(4'h2, 1'b0);
        wb(1'b1, 4'h0, 32'h0000_0101);
        req(4'h4, 1'b0);
        req(4'h8, 1'b1);
        // Clearing the enable mid-service must not abort the request
        wb(1'b1, 4'h0, 32'h0000_0001);
        wb(1'b0, 4'h4, 32'h0);
        chk(rdat, 32'h1);
        M.pulse(4'h1);
        #1 chk({31'h0, reqActive}, 32'h0);
        wb(1'b1, 4'h0, 32'h0000_0101);
        req(4'h2, 1'b1);
        M.pulse(4'h1);
        wb(1'b1, 4'h0, 32'h0000_0301);
        req(4'h4, 1'b1);
        wb(1'b1, 4'h0, 32'h0000_0001);
        wb(1'b0, 4'h4, 32'h0);
        chk(rdat, 32'h1);
        M.pulse(4'h1);
        wm(32'h0000_0014, 1'b1, 3'h4);
        wm(32'h0000_0004, 1'b0, 3'h1);
        wm(32'h0000_0011, 1'b0, 3'h1);
        wm(32'h0000_0012, 1'b0, 3'h1);
        wb(1'b0, 4'h4, 32'h0);
        chk(rdat, 32'h4);
        // Sideband outside 1X goes through the ordinary busy state
        wb(1'b1, 4'h0, 32'h0000_0304);
        req(4'h4, 1'b1);
        M.pulse(4'h1);
        // Frozen clock enable must swallow a request
        wb(1'b1, 4'h0, 32'h0000_0101);
        @(posedge core_clk);
        clkEn <= 1'b0;
        req(4'h8, 1'b0);
        @(posedge core_clk);
        clkEn <= 1'b1;
        req(4'h8, 1'b1);
        M.pulse(4'h1);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
